/* mps_defs.svh */
// register offsets, field positions, reset values and frame constants of the phy status tracker
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH

`define MPS_OFF_ACK_STATUS 8'h00
`define MPS_OFF_CONN_STATE 8'h04
`define MPS_OFF_RAW_EVENTS 8'h08
`define MPS_OFF_MASKED_EVENTS 8'h0c
`define MPS_OFF_SELECT0 8'h10
`define MPS_OFF_SELECT1 8'h14
`define MPS_OFF_IRQ_MASK 8'h18

`define MPS_SEL_ADDR_HI 4
`define MPS_SEL_ADDR_LO 0
`define MPS_SEL_EN_BIT 6

`define MPS_RST_VEC32 32'h0000_0000
`define MPS_RST_EV2 2'h0

`define MPS_OP_WRITE 2'h1
`define MPS_OP_READ 2'h2
`define MPS_GEN_STATUS_REG 5'h01
`define MPS_LINK_BIT 2

`define MPS_HDR_LAST 5'h0b
`define MPS_TA_LAST 5'h01
`define MPS_DATA_LAST 5'h0f
`define MPS_CNT_ZERO 5'h00
`define MPS_CNT_ONE 5'h01

`endif

/* mps_pkg.sv */
// types shared by the phy status tracker
package mps_pkg;

   // gray coded along idle, start, header, turnaround, data
   typedef enum logic [2:0]
   {
      MPS_IDLE = 3'h0,
      MPS_START = 3'h1,
      MPS_HDR = 3'h3,
      MPS_TA = 3'h2,
      MPS_DATA = 3'h6
   } mps_state_t;

   typedef struct packed
   {
      logic [2:0] mdc_s;
      logic [2:0] mdio_s;
      logic mdc_f;
      logic mdio_f;
      mps_state_t st;
      logic [4:0] cnt;
      logic [11:0] hdr;
      logic ack_bit;
      logic [15:0] data;
      logic [31:0] ack_status;
      logic [31:0] conn_state;
      logic [1:0] raw;
      logic [1:0] masked;
      logic [1:0][4:0] sel_addr;
      logic [1:0] sel_en;
      logic [1:0] irq_mask;
      logic wb_ack;
      logic [31:0] wb_dat;
   } mps_regs_t;

endpackage : mps_pkg

/* mps_status_tracker.sv */
// phy acknowledge and link status tracker snooping the management serial link, with wishbone registers
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "mps_defs.svh"

// Function
// RULE_01: keep a 32-bit acknowledge vector, setting the bit at a phy address when its latest access was acknowledged.
// RULE_02: clear that phy's acknowledge bit when an access to it is not acknowledged.
// RULE_03: update the acknowledge bit on every access to the phy, user or polling alike.
// RULE_04: a software one written to an acknowledge bit clears it and a zero leaves it alone.
// RULE_05: change a phy's link bit only after a read of that phy's generic status register.
// RULE_06: set the link bit when the status read shows link and the phy acknowledged the read.
// RULE_07: clear the link bit when the status read shows no link or the read was not acknowledged.
// RULE_08: the link state vector is read only and writes leave it unchanged.
// RULE_09: set a raw link-change event when the link bit of the monitored phy address changes.
// RULE_10: the raw event field is two bits, bit 0 for monitored select 0 and bit 1 for monitored select 1.
// RULE_11: a software one written to a raw event bit clears it and a zero has no effect.
// RULE_12: set a masked event bit only when the raw event occurs and that select register's interrupt enable is set.
// RULE_13: reserved upper bits of the raw event register read as zero and ignore writes.
module mps_status_tracker
   import mps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic irq_o
);

   mps_regs_t q;
   mps_regs_t next_q;

   logic mdc_agree;
   logic mdc_rise;
   logic line_bit;
   logic frame_done;
   logic [15:0] frame_data;
   logic [1:0] frame_op;
   logic [4:0] frame_phy;
   logic [4:0] frame_reg;
   logic frame_is_access;
   logic link_update;
   logic new_link;
   logic [1:0] link_change;
   logic bus_req;
   logic bus_write;
   logic [31:0] byte_mask;
   logic [31:0] clr_bits;

   // a level counts only once the second and third stages agree, which rejects a sample caught mid-change
   assign mdc_agree = (q.mdc_s[1] == q.mdc_s[2]);
   assign mdc_rise = mdc_agree & q.mdc_s[2] & ~q.mdc_f;
   assign line_bit = (q.mdio_s[1] == q.mdio_s[2]) ? q.mdio_s[2] : q.mdio_f;

   assign frame_op = q.hdr[11:10];
   assign frame_phy = q.hdr[9:5];
   assign frame_reg = q.hdr[4:0];
   assign frame_data = {q.data[14:0], line_bit};
   assign frame_done = mdc_rise & (q.st == MPS_DATA) & (q.cnt == `MPS_DATA_LAST);
   assign frame_is_access = (frame_op == `MPS_OP_READ) | (frame_op == `MPS_OP_WRITE);
   // only a read of the generic status register may move a link bit
   assign link_update = frame_done & (frame_op == `MPS_OP_READ) & (frame_reg == `MPS_GEN_STATUS_REG); // [RULE_05]
   assign new_link = q.ack_bit & frame_data[`MPS_LINK_BIT]; // [RULE_06] [RULE_07]

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1)
      begin : g_chan
         // channel gi follows monitored select register gi
         assign link_change[gi] = link_update & (frame_phy == q.sel_addr[gi]) &
                                  (q.conn_state[frame_phy] != new_link); // [RULE_09] [RULE_10]
      end
   endgenerate

   assign bus_req = wb_cyc_i & wb_stb_i;
   // the write lands on the edge at which ack is high, the same edge the master samples it
   assign bus_write = bus_req & wb_we_i & q.wb_ack;
   assign byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign clr_bits = wb_dat_i & byte_mask;

   always_comb
   begin
      next_q = q;
      next_q.mdc_s = {q.mdc_s[1:0], mdc_i};
      next_q.mdio_s = {q.mdio_s[1:0], mdio_i};
      if (mdc_agree)
      begin
         next_q.mdc_f = q.mdc_s[2];
      end
      next_q.mdio_f = line_bit;

      // frame tracker, advanced on each rising edge of the management clock
      if (mdc_rise)
      begin
         case (q.st)
            MPS_IDLE:
            begin
               if (!line_bit)
               begin
                  next_q.st = MPS_START;
               end
            end
            MPS_START:
            begin
               next_q.cnt = `MPS_CNT_ZERO;
               next_q.st = line_bit ? MPS_HDR : MPS_IDLE;
            end
            MPS_HDR:
            begin
               next_q.hdr = {q.hdr[10:0], line_bit};
               if (q.cnt == `MPS_HDR_LAST)
               begin
                  next_q.cnt = `MPS_CNT_ZERO;
                  next_q.st = MPS_TA;
               end
               else
               begin
                  next_q.cnt = q.cnt + `MPS_CNT_ONE;
               end
            end
            MPS_TA:
            begin
               if (q.cnt == `MPS_TA_LAST)
               begin
                  // the addressed phy pulls the second turnaround bit low to answer
                  next_q.ack_bit = ~line_bit;
                  next_q.cnt = `MPS_CNT_ZERO;
                  next_q.st = MPS_DATA;
               end
               else
               begin
                  next_q.cnt = q.cnt + `MPS_CNT_ONE;
               end
            end
            MPS_DATA:
            begin
               next_q.data = frame_data;
               if (q.cnt == `MPS_DATA_LAST)
               begin
                  next_q.st = MPS_IDLE;
               end
               else
               begin
                  next_q.cnt = q.cnt + `MPS_CNT_ONE;
               end
            end
            default:
            begin
               next_q.st = MPS_IDLE;
            end
         endcase
      end

      // software clears first so that a same-cycle hardware update wins
      if (bus_write)
      begin
         case (wb_adr_i)
            `MPS_OFF_ACK_STATUS:
            begin
               next_q.ack_status = q.ack_status & ~clr_bits; // [RULE_04]
            end
            `MPS_OFF_RAW_EVENTS:
            begin
               next_q.raw = q.raw & ~clr_bits[1:0]; // [RULE_11] [RULE_13]
            end
            `MPS_OFF_MASKED_EVENTS:
            begin
               next_q.masked = q.masked & ~clr_bits[1:0];
            end
            `MPS_OFF_SELECT0:
            begin
               if (wb_sel_i[0])
               begin
                  next_q.sel_addr[0] = wb_dat_i[`MPS_SEL_ADDR_HI:`MPS_SEL_ADDR_LO];
                  next_q.sel_en[0] = wb_dat_i[`MPS_SEL_EN_BIT];
               end
            end
            `MPS_OFF_SELECT1:
            begin
               if (wb_sel_i[0])
               begin
                  next_q.sel_addr[1] = wb_dat_i[`MPS_SEL_ADDR_HI:`MPS_SEL_ADDR_LO];
                  next_q.sel_en[1] = wb_dat_i[`MPS_SEL_EN_BIT];
               end
            end
            `MPS_OFF_IRQ_MASK:
            begin
               if (wb_sel_i[0])
               begin
                  next_q.irq_mask = wb_dat_i[1:0];
               end
            end
            default:
            begin
               // link state and unmapped offsets take no write
               next_q.conn_state = q.conn_state; // [RULE_08]
            end
         endcase
      end

      if (frame_done & frame_is_access)
      begin
         next_q.ack_status[frame_phy] = q.ack_bit; // [RULE_01] [RULE_02] [RULE_03]
      end
      if (link_update)
      begin
         next_q.conn_state[frame_phy] = new_link; // [RULE_06] [RULE_07]
      end
      next_q.raw = next_q.raw | link_change; // [RULE_09] [RULE_10]
      next_q.masked = next_q.masked | (link_change & q.sel_en); // [RULE_12]

      // registered slave: ack one cycle after the request, dropped the cycle after
      next_q.wb_ack = bus_req & ~q.wb_ack;
      if (bus_req & ~q.wb_ack)
      begin
         case (wb_adr_i)
            `MPS_OFF_ACK_STATUS: next_q.wb_dat = q.ack_status;
            `MPS_OFF_CONN_STATE: next_q.wb_dat = q.conn_state;
            `MPS_OFF_RAW_EVENTS: next_q.wb_dat = {30'h0, q.raw}; // [RULE_13]
            `MPS_OFF_MASKED_EVENTS: next_q.wb_dat = {30'h0, q.masked};
            `MPS_OFF_SELECT0: next_q.wb_dat = {25'h0, q.sel_en[0], 1'h0, q.sel_addr[0]};
            `MPS_OFF_SELECT1: next_q.wb_dat = {25'h0, q.sel_en[1], 1'h0, q.sel_addr[1]};
            `MPS_OFF_IRQ_MASK: next_q.wb_dat = {30'h0, q.irq_mask};
            default: next_q.wb_dat = `MPS_RST_VEC32;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= next_q;
      end
   end

   assign wb_ack_o = q.wb_ack;
   assign wb_dat_o = q.wb_dat;
   // level interrupt while any unmasked raw event stands
   assign irq_o = |(q.raw & q.irq_mask);

endmodule : mps_status_tracker
`default_nettype wire

/* mps_status_tracker_checker.sv */
// port assertions for the phy status tracker
`timescale 1ns/1ps
`default_nettype none
module mps_status_tracker_checker
   import mps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic mdc_i,
   input wire logic mdio_i,
   input wire logic irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic rd = wb_ack_o && !wb_we_i;
   chk_ack_delay: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack long");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
      else $error("ack unasked");
   chk_raw_upper: assert property (rd && wb_adr_i == 8'h08 |-> wb_dat_o[31:2] == 30'h0)
      else $error("raw upper set");
   chk_mask_upper: assert property (rd && wb_adr_i == 8'h0c |-> wb_dat_o[31:2] == 30'h0)
      else $error("masked upper set");
   chk_sel_layout: assert property (rd && wb_adr_i[7:3] == 5'h02 |->
      wb_dat_o[31:7] == 25'h0 && !wb_dat_o[5])
      else $error("select layout");
   chk_unmapped_zero: assert property (rd && wb_adr_i > 8'h18 |-> wb_dat_o == 32'h0)
      else $error("unmapped data");
   // only a cycle after an acknowledged register access, read or write, or after reset may the interrupt drop
   chk_irq_fall: assert property ($fell(irq_o) |-> $past(wb_ack_o) || $past(rst_i))
      else $error("irq fell alone");
   cover property ($rose(irq_o));
   cover property (rd && wb_adr_i == 8'h08 && wb_dat_o[1]);
   cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h00);
endmodule : mps_status_tracker_checker
bind mps_status_tracker mps_status_tracker_checker chk_u (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o,
   .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mdc_i, .mdio_i, .irq_o);
`default_nettype wire

/* mps_phy_model.sv */
// behavioural phy side of the management link
`timescale 1ns/1ps
`default_nettype none
module mps_phy_model
(
   output logic mdc_o,
   output logic mdio_o
);
   // clock stands low and the pulled-up line high between frames
   initial
   begin
      mdc_o = 1'b0;
      mdio_o = 1'b1;
   end
   task automatic frame(input logic [1:0] op, input logic [4:0] a, input logic [4:0] rg,
      input logic [15:0] d, input logic ack);
      logic [31:0] f;
      // an absent phy leaves turnaround and data to the pull-up
      f = {2'h1, op, a, rg, (op == 2'h2 && !ack) ? 18'h3ffff : {2'h2, d}};
      #37;
      for (int i = 31; i >= 0; i--)
      begin
         mdio_o = f[i];
         #400 mdc_o = 1'b1;
         #400 mdc_o = 1'b0;
      end
      mdio_o = 1'b1;
      #800;
   endtask : frame
endmodule : mps_phy_model
`default_nettype wire

/* mps_status_tracker_tb_top.sv */
// self-checking bench for the phy status tracker
`timescale 1ns/1ps
`default_nettype none
module mps_status_tracker_tb_top
   import mps_pkg::*;
;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h0;
   logic [31:0] dat = 32'h0, ack_e = 32'h0, link_e = 32'h0, exq[$];
   logic [1:0] raw_e = 2'h0, msk_e = 2'h0;
   logic [4:0] p, q;
   int failures = 0, comparisons = 0, seed = 93113;
   wire logic [31:0] dat_o;
   wire logic ack_o, irq_o, mdc, mdio;
   mps_phy_model phy_u (.mdc_o(mdc), .mdio_o(mdio));
   mps_status_tracker dut_u (.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_we_i(we),
      .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_ack_o(ack_o), .mdc_i(mdc), .mdio_i(mdio), .irq_o);
   initial
   begin
      forever #50 clk_i = ~clk_i;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic test_done();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   // reads note the expected word in the queue; d is that word
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      if (!w)
         exq.push_back(d);
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      cyc <= 1'b0;
      if (ack_o !== 1'b1)
      begin
         failures++;
         test_done();
      end
   endtask : wb
   always @(posedge clk_i)
      if (ack_o === 1'b1 && we === 1'b0)
         cmp(dat_o, exq.pop_front());
   // select 0 watches p with its enable set, select 1 watches q without
   task automatic fr(input logic [1:0] op, input logic [4:0] a, input logic [4:0] rg, input logic [15:0] d,
      input logic k);
      logic nl;
      phy_u.frame(op, a, rg, d, k);
      k = k || op == 2'h1;
      if (op == 2'h1 || op == 2'h2)
         ack_e[a] = k;
      if (op == 2'h2 && rg == 5'h01)
      begin
         nl = k && d[2];
         if (nl != link_e[a])
         begin
            raw_e = raw_e | {a == q, a == p};
            msk_e[0] = msk_e[0] | (a == p);
         end
         link_e[a] = nl;
      end
   endtask : fr
   task automatic all_regs();
      wb(1'b0, 8'h00, ack_e);
      wb(1'b0, 8'h04, link_e);
      wb(1'b0, 8'h08, {30'h0, raw_e});
      wb(1'b0, 8'h0c, {30'h0, msk_e});
      cmp({31'h0, irq_o}, {31'h0, raw_e[0]});
   endtask : all_regs
   initial
   begin
      p = 5'($random(seed));
      q = p ^ 5'h11;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      all_regs();
      wb(1'b1, 8'h1c, 32'hffffffff);
      wb(1'b0, 8'h1c, 32'h0);
      wb(1'b1, 8'h10, {25'h0, 2'h2, p});
      wb(1'b1, 8'h14, {27'h0, q});
      wb(1'b1, 8'h18, 32'h1);
      wb(1'b0, 8'h10, {25'h0, 2'h2, p});
      wb(1'b0, 8'h14, {27'h0, q});
      wb(1'b0, 8'h18, 32'h1);
      $display("register map done");
      for (int o = 0; o < 4; o++)
      begin
         fr(o[1:0], p, 5'h01, 16'($random(seed)) | 16'h4, 1'b1);
         all_regs();
      end
      $display("opcodes done");
      fr(2'h2, p, 5'h02, 16'h0, 1'b1);
      wb(1'b1, 8'h04, 32'hffffffff);
      wb(1'b1, 8'h08, 32'hfffffffc);
      all_regs();
      fr(2'h1, q, 5'h00, 16'h0, 1'b0);
      fr(2'h2, q, 5'h01, 16'h4, 1'b0);
      all_regs();
      fr(2'h2, q, 5'h01, 16'h4, 1'b1);
      all_regs();
      $display("second select done");
      wb(1'b1, 8'h08, 32'hffffffff);
      wb(1'b1, 8'h0c, 32'hffffffff);
      raw_e = 2'h0;
      msk_e = 2'h0;
      all_regs();
      fr(2'h2, p, 5'h01, 16'hfffb, 1'b1);
      wb(1'b1, 8'h00, 32'h1 << p);
      ack_e[p] = 1'b0;
      all_regs();
      $display("link down done");
      @(posedge clk_i);
      test_done();
   end
   initial
   begin
      #3000000;
      failures++;
      test_done();
   end
endmodule : mps_status_tracker_tb_top
`default_nettype wire
